// ### supply_monitor_flag_logic.sv
// How it works
// - Either comparator low sets the flag
// - Both good 250 ms, flag clears itself
// - Software clear ignored while a supply low
// - Bit 7 reads live digital comparator
// - Bit 6 reads live analog comparator
// - Interrupt only when external enable set
// - Comparator glitches filtered before use
// - Bits 4:3 select digital trip point
// - Five-volt part: digital trip select unusable
// - Trip codes 4.63/3.08/2.93/2.63 V, drive comparator
// - Bits 2:1 select analog trip point
// - Bit 0 enables low-supply detection; status bits and software flag writes work with it clear
`timescale 1ns/1ps
module supply_monitor_flag_logic #(
  parameter int unsigned HOLD_TICKS     = supply_watch_pkg::HOLD_TICKS_DEF,
  parameter int unsigned FILTER_CYCLES  = supply_watch_pkg::FILTER_DEF,
  parameter bit          FIVE_VOLT_PART = 1'b0
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Special-function register bus
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  // Analog comparators
  input  wire logic       digital_supply_cmp_i,
  input  wire logic       analog_supply_cmp_i,
  output logic      [1:0] digital_trip_select_o,
  output logic      [1:0] analog_trip_select_o,
  output logic            monitor_on_o,
  // Interrupt controller
  input  wire logic       irq_enable_priority_two_i,
  output logic            supply_low_irq_o
);
  localparam int unsigned HW = $clog2(HOLD_TICKS + 1);
  localparam int unsigned DW = $clog2(supply_watch_pkg::TICK_CYCLES + 1);

  supply_watch_pkg::ctrl_s       rst_img;
  supply_watch_pkg::ctrl_s       rd_img;
  supply_watch_pkg::hold_state_e state_q, state_d;

  logic          dcmp_good, acmp_good;
  logic          supply_low;
  logic          ctrl_wr, ctrl_rd;
  logic [1:0]    dtrip_q, dtrip_d;
  logic [1:0]    atrip_q, atrip_d;
  logic          on_q,    on_d;
  logic          flag_q,  flag_d;
  logic [HW-1:0] hold_q,  hold_d;
  logic [DW-1:0] div_q,   div_d;
  logic          tick;
  logic          hold_done;
  logic [7:0]    rdata_q, rdata_d;

  assign rst_img = supply_watch_pkg::CTRL_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator conditioning
  supply_cmp_filter #(
    .CYCLES (FILTER_CYCLES)
  ) u_dfilt (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (digital_supply_cmp_i),
    .good_o    (dcmp_good)
  );

  supply_cmp_filter #(
    .CYCLES (FILTER_CYCLES)
  ) u_afilt (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (analog_supply_cmp_i),
    .good_o    (acmp_good)
  );

  // A disabled monitor never reports a low supply
  assign supply_low = on_q && (!dcmp_good || !acmp_good);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and writable fields
  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == supply_watch_pkg::CTRL_ADDR);
  assign ctrl_rd = sfr_rd_i && (sfr_addr_i == supply_watch_pkg::CTRL_ADDR);

  always_comb begin
    dtrip_d = dtrip_q;
    atrip_d = atrip_q;
    on_d    = on_q;
    if (ctrl_wr) begin
      dtrip_d = sfr_wdata_i[supply_watch_pkg::BIT_DTRIP +: 2];
      atrip_d = sfr_wdata_i[supply_watch_pkg::BIT_ATRIP +: 2];
      on_d    = sfr_wdata_i[supply_watch_pkg::BIT_ON];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dtrip_q <= supply_watch_pkg::CTRL_RESET[supply_watch_pkg::BIT_DTRIP +: 2];
      atrip_q <= supply_watch_pkg::CTRL_RESET[supply_watch_pkg::BIT_ATRIP +: 2];
      on_q    <= supply_watch_pkg::CTRL_RESET[supply_watch_pkg::BIT_ON];
    end else begin
      dtrip_q <= dtrip_d;
      atrip_q <= atrip_d;
      on_q    <= on_d;
    end
  end

  // The five-volt part resets below the top trip point, so only that code is driven
  assign digital_trip_select_o = FIVE_VOLT_PART ? supply_watch_pkg::TRIP_4V63 : dtrip_q;
  assign analog_trip_select_o  = atrip_q;
  assign monitor_on_o          = on_q;

  ////////////////////////////////////////////////////////////////////////////
  // Hold timer: microsecond ticks counted while both supplies stay good
  assign tick      = (div_q == DW'(supply_watch_pkg::TICK_CYCLES - 1));
  // A low arriving in the expiry cycle must not let the timer clear the flag
  assign hold_done = (state_q == supply_watch_pkg::HOLD_RUN) && tick && !supply_low &&
                     (hold_q == HW'(HOLD_TICKS - 1));

  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    div_d   = '0;
    case (state_q)
      supply_watch_pkg::HOLD_IDLE: begin
        hold_d = '0;
        if (flag_q && !supply_low) begin
          state_d = supply_watch_pkg::HOLD_RUN;
        end
      end
      supply_watch_pkg::HOLD_RUN: begin
        if (supply_low || !flag_q || hold_done) begin
          state_d = supply_watch_pkg::HOLD_IDLE;
          hold_d  = '0;
        end else begin
          div_d = tick ? '0 : div_q + DW'(1);
          if (tick) begin
            hold_d = hold_q + HW'(1);
          end
        end
      end
      default: begin
        state_d = supply_watch_pkg::HOLD_IDLE;
        hold_d  = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= supply_watch_pkg::HOLD_IDLE;
      hold_q  <= '0;
      div_q   <= '0;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      div_q   <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-supply flag: hardware set beats any software write
  always_comb begin
    flag_d = flag_q;
    if (supply_low) begin
      flag_d = 1'b1;
    end else if (hold_done) begin
      flag_d = 1'b0;
    end else if (ctrl_wr) begin
      flag_d = sfr_wdata_i[supply_watch_pkg::BIT_FLAG];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_q <= supply_watch_pkg::CTRL_RESET[supply_watch_pkg::BIT_FLAG];
    end else begin
      flag_q <= flag_d;
    end
  end

  assign supply_low_irq_o = flag_q && irq_enable_priority_two_i;

  ////////////////////////////////////////////////////////////////////////////
  // Read-back, one cycle after the strobe; other addresses answer zero
  always_comb begin
    rd_img       = rst_img;
    rd_img.dcmp  = dcmp_good;
    rd_img.acmp  = acmp_good;
    rd_img.flag  = flag_q;
    rd_img.dtrip = dtrip_q;
    rd_img.atrip = atrip_q;
    rd_img.on    = on_q;
    rdata_d      = ctrl_rd ? rd_img : 8'h00;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ctrl_write;
    sfr_wr_i && (sfr_addr_i == supply_watch_pkg::CTRL_ADDR);
  endsequence

  sequence s_ctrl_read;
    sfr_rd_i && (sfr_addr_i == supply_watch_pkg::CTRL_ADDR);
  endsequence

  chk_flag_set_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    supply_low |=> flag_q [*1])
    else $error("flag not set by a low supply");

  chk_flag_auto_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hold_done |=> !flag_q && (state_q == supply_watch_pkg::HOLD_IDLE))
    else $error("flag not cleared when the hold timer expired");

  chk_timer_restart: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    supply_low |=> (hold_q == '0) && (state_q == supply_watch_pkg::HOLD_IDLE))
    else $error("hold timer not abandoned on a new low");

  chk_clear_refused: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_ctrl_write and (!sfr_wdata_i[supply_watch_pkg::BIT_FLAG] && supply_low)) |=> flag_q)
    else $error("software cleared the flag during a low supply");

  chk_read_dcmp: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ctrl_read |=> sfr_rdata_o[supply_watch_pkg::BIT_DCMP] == $past(dcmp_good))
    else $error("bit 7 does not show the digital comparator");

  chk_read_acmp: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ctrl_read |=> sfr_rdata_o[supply_watch_pkg::BIT_ACMP] == $past(acmp_good))
    else $error("bit 6 does not show the analog comparator");

  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    supply_low && irq_enable_priority_two_i ##1 irq_enable_priority_two_i |-> supply_low_irq_o)
    else $error("interrupt not raised for an enabled low supply");

  chk_irq_masked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !irq_enable_priority_two_i |-> !supply_low_irq_o)
    else $error("interrupt raised while disabled");

  chk_dtrip_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ctrl_write |=> digital_trip_select_o == (FIVE_VOLT_PART ? supply_watch_pkg::TRIP_4V63 :
                     $past(sfr_wdata_i[supply_watch_pkg::BIT_DTRIP +: 2])))
    else $error("digital trip select not driven from the written field");

  chk_atrip_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ctrl_write |=> analog_trip_select_o == $past(sfr_wdata_i[supply_watch_pkg::BIT_ATRIP +: 2]))
    else $error("analog trip select not driven from the written field");

  chk_monitor_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_ctrl_write and !sfr_wdata_i[supply_watch_pkg::BIT_ON]) |=> !supply_low && !monitor_on_o)
    else $error("disabled monitor still reports a low supply");

endmodule // supply_monitor_flag_logic

// ### supply_watch_pkg.sv
package supply_watch_pkg;

  // Register placement on the core's special-function bus
  localparam logic [7:0] CTRL_ADDR  = 8'hdf;
  localparam logic [7:0] CTRL_RESET = 8'hde;

  // Field positions in supply_monitor_control
  localparam int unsigned BIT_DCMP  = 7;
  localparam int unsigned BIT_ACMP  = 6;
  localparam int unsigned BIT_FLAG  = 5;
  localparam int unsigned BIT_DTRIP = 3;
  localparam int unsigned BIT_ATRIP = 1;
  localparam int unsigned BIT_ON    = 0;

  // Trip point encodings, shared by both supplies
  localparam logic [1:0] TRIP_4V63 = 2'h0;
  localparam logic [1:0] TRIP_3V08 = 2'h1;
  localparam logic [1:0] TRIP_2V93 = 2'h2;
  localparam logic [1:0] TRIP_2V63 = 2'h3;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned TICK_NS        = 1000;
  localparam int unsigned TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_MS        = 250;
  localparam int unsigned HOLD_TICKS_DEF = (HOLD_MS * 1000 * 1000) / TICK_NS;
  localparam int unsigned FILTER_DEF     = 16;

  // Control register image
  typedef struct packed {
    logic       dcmp;
    logic       acmp;
    logic       flag;
    logic [1:0] dtrip;
    logic [1:0] atrip;
    logic       on;
  } ctrl_s;

  typedef enum logic [0:0] {
    HOLD_IDLE,
    HOLD_RUN
  } hold_state_e;

endpackage

// ### supply_cmp_filter.sv
`timescale 1ns/1ps
module supply_cmp_filter #(
  parameter int unsigned CYCLES = supply_watch_pkg::FILTER_DEF
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Comparator
  input  wire logic raw_i,
  output logic      good_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic          sync1_q, sync2_q;
  logic          out_q,   out_d;
  logic [CW-1:0] cnt_q,   cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Output changes only after CYCLES agreeing samples; shorter pulses are lost
  always_comb begin
    out_d = out_q;
    cnt_d = '0;
    if (sync2_q != out_q) begin
      if (cnt_q == CW'(CYCLES - 1)) begin
        out_d = sync2_q;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      out_q   <= 1'b1;
      cnt_q   <= '0;
    end else begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
      out_q   <= out_d;
      cnt_q   <= cnt_d;
    end
  end

  assign good_o = out_q;

  chk_filter_glitch_block: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (out_q != $past(out_q)) |-> ($past(cnt_q) == CW'(CYCLES - 1)))
    else $error("filter output moved before the settle count");

endmodule // supply_cmp_filter

// ### supply_cmp_model.sv
`timescale 1ns/1ps
module supply_cmp_model (
  // Trip selection from the monitor
  input  wire logic [1:0] digital_trip_select_i,
  input  wire logic [1:0] analog_trip_select_i,
  // Comparator outputs, 1 = supply above its trip point
  output logic            digital_supply_cmp_o,
  output logic            analog_supply_cmp_o
);
  // Supply levels in millivolts, set by the bench
  int dvdd_mv = 3300;
  int avdd_mv = 3300;

  function automatic int trip_mv(input logic [1:0] code);
    case (code)
      2'h0: trip_mv = 4630;
      2'h1: trip_mv = 3080;
      2'h2: trip_mv = 2930;
      default: trip_mv = 2630;
    endcase
  endfunction

  // Real comparators are asynchronous, so outputs follow the level at once
  assign digital_supply_cmp_o = dvdd_mv > trip_mv(digital_trip_select_i);
  assign analog_supply_cmp_o  = avdd_mv > trip_mv(analog_trip_select_i);
endmodule // supply_cmp_model

// ### supply_monitor_flag_logic_tb_top.sv
`timescale 1ns/1ps
module supply_monitor_flag_logic_tb_top;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic       wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       dcmp;
  logic       acmp;
  logic [1:0] dtrip;
  logic [1:0] atrip;
  logic       mon_on;
  logic       irq_en = 1'b1;
  logic       irq;
  logic [1:0] dtrip5;
  int         fails = 0;
  int         n_tests = 0;

  always #4 mclk = ~mclk;

  // Short hold and filter counts keep the run brief
  supply_monitor_flag_logic #(.HOLD_TICKS(4), .FILTER_CYCLES(4)) u_supply_monitor_flag_logic (
    .mclk_i(mclk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .digital_supply_cmp_i(dcmp), .analog_supply_cmp_i(acmp),
    .digital_trip_select_o(dtrip), .analog_trip_select_o(atrip), .monitor_on_o(mon_on),
    .irq_enable_priority_two_i(irq_en), .supply_low_irq_o(irq));

  supply_cmp_model u_supply_cmp_model (
    .digital_trip_select_i(dtrip), .analog_trip_select_i(atrip),
    .digital_supply_cmp_o(dcmp), .analog_supply_cmp_o(acmp));

  // Five-volt variant shares the bus; only its digital trip output is watched
  supply_monitor_flag_logic #(.HOLD_TICKS(4), .FILTER_CYCLES(4), .FIVE_VOLT_PART(1'b1))
    u_supply_monitor_flag_logic_five (
    .mclk_i(mclk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(),
    .digital_supply_cmp_i(dcmp), .analog_supply_cmp_i(acmp),
    .digital_trip_select_o(dtrip5), .analog_trip_select_o(), .monitor_on_o(),
    .irq_enable_priority_two_i(irq_en), .supply_low_irq_o());

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic supply(input int d_mv, input int a_mv);
    u_supply_cmp_model.dvdd_mv = d_mv;
    u_supply_cmp_model.avdd_mv = a_mv;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic check_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cmp8(what, exp, rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_reg("ctrl reset", supply_watch_pkg::CTRL_ADDR, supply_watch_pkg::CTRL_RESET);
    cmp8("trip outputs", 8'h0f, {4'h0, dtrip, atrip});
    cmp8("monitor on", 8'h00, {7'h00, mon_on});
    check_reg("unmapped read", 8'hde, 8'h00);
  endtask

  task automatic t_regs();
    // Monitor stays off while code 00 puts a comparator below its trip point
    for (int c = 0; c < 4; c++) begin
      wr_reg(supply_watch_pkg::CTRL_ADDR, {3'h0, c[1:0], ~c[1:0], 1'b0});
      cmp8("trip codes", {4'h0, c[1:0], ~c[1:0]}, {4'h0, dtrip, atrip});
      cmp8("five-volt trip", 8'h00, {6'h00, dtrip5});
    end
    wr_reg(supply_watch_pkg::CTRL_ADDR, 8'h0a);
    cyc(12);
    wr_reg(supply_watch_pkg::CTRL_ADDR, 8'h0b);
    cmp8("monitor on", 8'h01, {7'h00, mon_on});
    check_reg("read-only bits", supply_watch_pkg::CTRL_ADDR, 8'hcb);
    wr_reg(8'hde, 8'h00);
    check_reg("unmapped write", supply_watch_pkg::CTRL_ADDR, 8'hcb);
  endtask

  task automatic t_glitch();
    supply(2000, 3300);
    cyc(2);
    supply(3300, 3300);
    cyc(20);
    cmp8("glitch irq", 8'h00, {7'h00, irq});
  endtask

  task automatic t_low_digital();
    supply(2000, 3300);
    cyc(12);
    check_reg("digital low", supply_watch_pkg::CTRL_ADDR, 8'h6b);
    cmp8("irq enabled", 8'h01, {7'h00, irq});
    irq_en = 1'b0;
    cyc(1);
    cmp8("irq masked", 8'h00, {7'h00, irq});
    irq_en = 1'b1;
    wr_reg(supply_watch_pkg::CTRL_ADDR, 8'h0b);
    check_reg("clear while low", supply_watch_pkg::CTRL_ADDR, 8'h6b);
    supply(3300, 3300);
    cyc(200);
    supply(2000, 3300);
    cyc(12);
    supply(3300, 3300);
    cyc(470);
    cmp8("flag held", 8'h01, {7'h00, irq});
    cyc(60);
    cmp8("flag expired", 8'h00, {7'h00, irq});
    check_reg("after expiry", supply_watch_pkg::CTRL_ADDR, 8'hcb);
  endtask

  task automatic t_low_analog();
    supply(3300, 2000);
    cyc(12);
    check_reg("analog low", supply_watch_pkg::CTRL_ADDR, 8'hab);
    supply(3300, 3300);
    cyc(20);
    wr_reg(supply_watch_pkg::CTRL_ADDR, 8'h0b);
    check_reg("clear when good", supply_watch_pkg::CTRL_ADDR, 8'hcb);
  endtask

  task automatic t_disabled();
    wr_reg(supply_watch_pkg::CTRL_ADDR, 8'h0a);
    supply(2000, 3300);
    cyc(12);
    cmp8("irq when off", 8'h00, {7'h00, irq});
    supply(3300, 3300);
    cyc(12);
    check_reg("flag when off", supply_watch_pkg::CTRL_ADDR, 8'hca);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_glitch();
    t_low_digital();
    t_low_analog();
    t_disabled();
    tally_and_finish();
  end

  // Whole sequence needs under 1500 cycles
  initial begin
    repeat (6000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule // supply_monitor_flag_logic_tb_top
